// File: mfr_pkg.sv
// Constants for the multi-lane flash read sequencer
// Function
// - Opcode 3Bh is dual-output read, 3 or 4 address bytes; 3Ch always 4.
// - Dual-output data drives two bits per clock on lines 0 and 1, falling edge.
// - Dual-output read has zero or eight dummy cycles; input ignored then.
// - Any start byte; address increments per byte, wraps to zero past the top.
// - Opcode 6Bh is quad-output read, 3 or 4 address bytes; 6Ch always 4.
// - Quad-output data drives one nibble per clock, changed on falling edge.
// - Quad-output read works only while the four-lane enable bit is one.
// - Quad-output read inserts latency-code dummy cycles; all lines don't-care.
// - Opcode BBh is dual-I/O read, 3 or 4 address bytes; BCh always 4.
// - Dual-I/O address comes two bits per rising edge on lines 0 and 1.
// - High-performance table: instruction, address, dummy, no mode cycles.
// - Enhanced table: four mode cycles between address and dummy period.
// - Continuation decided from mode upper nibble only; lower nibble ignored.
// - Mode Axh keeps continuous mode; next frame starts with address.
// - Any other mode value leaves continuous mode at next select rise.
// - A frame of eight or fewer clocks without valid instruction leaves continuous mode.
// - Dual-I/O dummy count comes from the latency code field.
// - After dual-I/O latency, two bits per clock on lines 0 and 1.
// - Each command outside continuous mode opens with an 8-bit opcode, one bit per rising edge.
// - Four-byte select set makes legacy opcodes take four address bytes.
// - Three-byte commands take high address bits from the bank register.
package mfr_pkg;
    localparam logic [7:0] OP_DUAL_OUT      = 8'h3B;
    localparam logic [7:0] OP_DUAL_OUT_W    = 8'h3C;
    localparam logic [7:0] OP_QUAD_OUT      = 8'h6B;
    localparam logic [7:0] OP_QUAD_OUT_W    = 8'h6C;
    localparam logic [7:0] OP_DUAL_IO       = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_W     = 8'hBC;
    localparam logic [3:0] MODE_CONTINUE    = 4'hA;
    localparam logic [7:0] OPCODE_BITS      = 8'h08;
    localparam logic [7:0] MODE_CYCLES      = 8'h04;
    localparam logic [7:0] SHORT_FRAME_MAX  = 8'h08;
    localparam logic [7:0] DUAL_OUT_DUMMY   = 8'h08;
    localparam logic [1:0] LATENCY_NO_DUMMY = 2'h3;
    localparam logic [7:0] BANK_RESET       = 8'h00;

    typedef enum logic [5:0] {
        MFR_OPCODE = 6'h01,
        MFR_ADDR   = 6'h02,
        MFR_MODE   = 6'h04,
        MFR_DUMMY  = 6'h08,
        MFR_DATA   = 6'h10,
        MFR_IDLE   = 6'h20
    } mfr_state_type;

    typedef enum logic [2:0] {
        MFR_CMD_DOUT = 3'h1,
        MFR_CMD_QOUT = 3'h2,
        MFR_CMD_DIO  = 3'h4
    } mfr_cmd_type;

    // Dummy cycles for the latency code; a table entry outside this block
    function automatic logic [7:0] mfr_dummy(input logic [1:0] code);
        case (code)
            2'h0:    mfr_dummy = 8'h04;
            2'h1:    mfr_dummy = 8'h04;
            2'h2:    mfr_dummy = 8'h05;
            default: mfr_dummy = 8'h00;
        endcase
    endfunction
endpackage

// File: mfr_array.sv
// Small synchronous read memory standing in for the flash array
`timescale 1ns/100ps
`default_nettype none
module mfr_array #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic [ADDR_W-1:0] i_raddr,
    output logic      [7:0]        o_rdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// File: mfr_sequencer.sv
// Multi-lane SDR array read sequencer (dual out, quad out, dual I/O)
`timescale 1ns/100ps
`default_nettype none
module mfr_sequencer #(
    parameter int ARRAY_AW = 8
) (
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    input  wire logic                i_sck,
    input  wire logic                i_cs_n,
    input  wire logic [3:0]          i_io,
    output logic      [3:0]          o_io,
    output logic      [3:0]          o_io_oe,
    input  wire logic                i_four_byte_addr_select,
    input  wire logic                i_quad_enable,
    input  wire logic [1:0]          i_latency_code,
    input  wire logic                i_enhanced_latency_table,
    input  wire logic [7:0]          i_bank_addr,
    input  wire logic                i_mem_we,
    input  wire logic [ARRAY_AW-1:0] i_mem_waddr,
    input  wire logic [7:0]          i_mem_wdata,
    output logic                     o_busy,
    output logic                     o_execute_in_place
);
    // Refused at elaboration: the array is addressed from the low bits of the counter
    if (ARRAY_AW < 1 || ARRAY_AW > 24) begin : g_aw_check
        $error("ARRAY_AW out of range");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] sck_meta;
    logic [1:0] cs_meta;
    logic [3:0] io_meta;
    logic [3:0] io_s;
    logic       sck_s;
    logic       sck_d;
    logic       cs_s;
    logic       cs_d;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sck_meta <= 2'h0;
            cs_meta  <= 2'h3;
            io_meta  <= 4'h0;
            io_s     <= 4'h0;
            sck_d    <= 1'b0;
            cs_d     <= 1'b1;
        end else begin
            sck_meta <= {sck_meta[0], i_sck};
            cs_meta  <= {cs_meta[0], i_cs_n};
            io_meta  <= i_io;
            io_s     <= io_meta;
            sck_d    <= sck_s;
            cs_d     <= cs_s;
        end
    end

    assign sck_s = sck_meta[1];
    assign cs_s  = cs_meta[1];

    logic rise;
    logic fall;
    logic cs_rise;
    assign rise    = !cs_s && sck_s && !sck_d;
    assign fall    = !cs_s && !sck_s && sck_d;
    assign cs_rise = cs_s && !cs_d;

    // ----------------------------------------------------------------
    // Command state
    // ----------------------------------------------------------------
    mfr_pkg::mfr_state_type state;
    mfr_pkg::mfr_cmd_type   cmd;
    logic [7:0]  bit_cnt;
    logic [7:0]  opcode;
    logic [31:0] addr;
    logic [7:0]  addr_bits;
    logic [7:0]  mode_byte;
    logic [7:0]  dummy_len;
    logic [7:0]  frame_clocks;
    logic        cont_mode;
    logic        mode_keep;
    logic        next_cont_mode;
    logic        lanes2_in;
    logic [7:0]  next_opcode;
    logic [7:0]  rdata;
    logic [7:0]  shifter;
    logic [2:0]  bits_left;
    logic        got_mode;

    assign next_opcode = {opcode[6:0], io_s[0]};
    assign lanes2_in   = (cmd == mfr_pkg::MFR_CMD_DIO);

    function automatic logic wide_op(input logic [7:0] op);
        wide_op = op == mfr_pkg::OP_DUAL_OUT_W || op == mfr_pkg::OP_QUAD_OUT_W
               || op == mfr_pkg::OP_DUAL_IO_W;
    endfunction

    // Reads whose select rises before data return still apply a mode byte already fully captured;
    // the device simply abandons them.
    always_ff @(posedge i_clk) begin
        if (i_reset || cs_rise) begin
            state   <= next_cont_mode && !i_reset
                       ? mfr_pkg::MFR_ADDR : mfr_pkg::MFR_OPCODE;
            bit_cnt <= 8'h00;
        end else if (rise) begin
            case (state)
                mfr_pkg::MFR_OPCODE: begin
                    bit_cnt <= bit_cnt + 8'h01;
                    if (bit_cnt == mfr_pkg::OPCODE_BITS - 8'h01) begin
                        bit_cnt <= 8'h00;
                        state   <= mfr_pkg::MFR_IDLE;
                        case (next_opcode)
                            mfr_pkg::OP_DUAL_OUT, mfr_pkg::OP_DUAL_OUT_W: begin
                                state <= mfr_pkg::MFR_ADDR;
                            end
                            mfr_pkg::OP_QUAD_OUT, mfr_pkg::OP_QUAD_OUT_W: begin
                                if (i_quad_enable) begin
                                    state <= mfr_pkg::MFR_ADDR;
                                end
                            end
                            mfr_pkg::OP_DUAL_IO, mfr_pkg::OP_DUAL_IO_W: begin
                                state <= mfr_pkg::MFR_ADDR;
                            end
                            default: state <= mfr_pkg::MFR_IDLE;
                        endcase
                    end
                end
                mfr_pkg::MFR_ADDR: begin
                    bit_cnt <= bit_cnt + (lanes2_in ? 8'h02 : 8'h01);
                    if (bit_cnt + (lanes2_in ? 8'h02 : 8'h01) == addr_bits) begin
                        bit_cnt <= 8'h00;
                        if (lanes2_in && i_enhanced_latency_table) begin
                            state <= mfr_pkg::MFR_MODE;
                        end else if (dummy_len == 8'h00) begin
                            state <= mfr_pkg::MFR_DATA;
                        end else begin
                            state <= mfr_pkg::MFR_DUMMY;
                        end
                    end
                end
                mfr_pkg::MFR_MODE: begin
                    bit_cnt <= bit_cnt + 8'h01;
                    if (bit_cnt == mfr_pkg::MODE_CYCLES - 8'h01) begin
                        bit_cnt <= 8'h00;
                        state <= dummy_len == 8'h00 ? mfr_pkg::MFR_DATA : mfr_pkg::MFR_DUMMY;
                    end
                end
                mfr_pkg::MFR_DUMMY: begin
                    bit_cnt <= bit_cnt + 8'h01;
                    if (bit_cnt == dummy_len - 8'h01) begin
                        bit_cnt <= 8'h00;
                        state   <= mfr_pkg::MFR_DATA;
                    end
                end
                mfr_pkg::MFR_DATA: state <= mfr_pkg::MFR_DATA;
                mfr_pkg::MFR_IDLE: state <= mfr_pkg::MFR_IDLE;
                default: state <= mfr_pkg::MFR_OPCODE;
            endcase
        end
    end

    // Opcode, command kind, address width and dummy length
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            opcode    <= 8'h00;
            cmd       <= mfr_pkg::MFR_CMD_DOUT;
            addr_bits <= 8'h18;
            dummy_len <= 8'h00;
        end else if (cs_rise && next_cont_mode) begin
            cmd       <= mfr_pkg::MFR_CMD_DIO;
        end else if (rise && state == mfr_pkg::MFR_OPCODE) begin
            opcode <= next_opcode;
            if (bit_cnt == mfr_pkg::OPCODE_BITS - 8'h01) begin
                addr_bits <= (wide_op(next_opcode) || i_four_byte_addr_select)
                             ? 8'h20 : 8'h18;
                if (next_opcode == mfr_pkg::OP_DUAL_OUT
                        || next_opcode == mfr_pkg::OP_DUAL_OUT_W) begin
                    cmd       <= mfr_pkg::MFR_CMD_DOUT;
                    dummy_len <= i_latency_code == mfr_pkg::LATENCY_NO_DUMMY
                                 ? 8'h00 : mfr_pkg::DUAL_OUT_DUMMY;
                end else if (next_opcode[6:5] == 2'h3) begin
                    cmd       <= mfr_pkg::MFR_CMD_QOUT;
                    dummy_len <= mfr_pkg::mfr_dummy(i_latency_code);
                end else begin
                    cmd       <= mfr_pkg::MFR_CMD_DIO;
                    dummy_len <= mfr_pkg::mfr_dummy(i_latency_code);
                end
            end
        end
    end

    // Address capture and byte advance
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            addr <= 32'h0;
        end else if (cs_rise) begin
            addr <= 32'h0;
        end else if (rise && state == mfr_pkg::MFR_ADDR) begin
            if (lanes2_in) begin
                addr <= {addr[29:0], io_s[1:0]};
            end else begin
                addr <= {addr[30:0], io_s[0]};
            end
            // Bank byte placed so that the remaining shifts carry it to bits 31..24
            if (addr_bits == 8'h18 && bit_cnt == 8'h00) begin
                addr <= {23'h0, i_bank_addr, io_s[0]};
                if (lanes2_in) begin
                    addr <= {22'h0, i_bank_addr, io_s[1:0]};
                end
            end
        end else if (fall && state == mfr_pkg::MFR_DATA && bits_left == 3'h0) begin
            addr <= addr + 32'h1;
        end
    end

    // Mode byte and continuous dual-I/O mode
    assign mode_keep = mode_byte[7:4] == mfr_pkg::MODE_CONTINUE;

    // Continuation as it stands after this select rise; the command state
    // must follow the same decision in the same cycle, not the old flag
    always_comb begin
        next_cont_mode = cont_mode;
        if (got_mode) begin
            next_cont_mode = mode_keep;
        end else if (cont_mode && frame_clocks <= mfr_pkg::SHORT_FRAME_MAX) begin
            next_cont_mode = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_byte    <= 8'h00;
            got_mode     <= 1'b0;
            cont_mode    <= 1'b0;
            frame_clocks <= 8'h00;
        end else begin
            if (rise && state == mfr_pkg::MFR_MODE) begin
                mode_byte <= {mode_byte[5:0], io_s[1:0]};
                got_mode  <= bit_cnt == mfr_pkg::MODE_CYCLES - 8'h01;
            end
            if (rise && frame_clocks != 8'hFF) begin
                frame_clocks <= frame_clocks + 8'h01;
            end
            if (cs_rise) begin
                frame_clocks <= 8'h00;
                got_mode     <= 1'b0;
                cont_mode    <= next_cont_mode;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data return
    // ----------------------------------------------------------------
    mfr_array #(
        .ADDR_W(ARRAY_AW)
    ) mfr_array_i (
        .i_clk  (i_clk),
        .i_we   (i_mem_we),
        .i_waddr(i_mem_waddr),
        .i_wdata(i_mem_wdata),
        .i_raddr(addr[ARRAY_AW-1:0]),
        .o_rdata(rdata)
    );

    always_ff @(posedge i_clk) begin
        if (i_reset || cs_rise) begin
            o_io      <= 4'h0;
            o_io_oe   <= 4'h0;
            shifter   <= 8'h00;
            bits_left <= 3'h0;
        end else if (fall && state == mfr_pkg::MFR_DATA) begin
            if (cmd == mfr_pkg::MFR_CMD_QOUT) begin
                o_io_oe <= 4'hF;
                if (bits_left == 3'h0) begin
                    o_io      <= rdata[7:4];
                    shifter   <= {rdata[3:0], 4'h0};
                    bits_left <= 3'h1;
                end else begin
                    o_io      <= shifter[7:4];
                    bits_left <= 3'h0;
                end
            end else begin
                o_io_oe <= 4'h3;
                if (bits_left == 3'h0) begin
                    o_io      <= {2'h0, rdata[7:6]};
                    shifter   <= {rdata[5:0], 2'h0};
                    bits_left <= 3'h3;
                end else begin
                    o_io      <= {2'h0, shifter[7:6]};
                    shifter   <= {shifter[5:0], 2'h0};
                    bits_left <= bits_left - 3'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_busy             <= 1'b0;
            o_execute_in_place <= 1'b0;
        end else begin
            o_busy             <= !cs_s;
            o_execute_in_place <= cont_mode;
        end
    end
endmodule
`default_nettype wire

// File: mfr_sequencer_checker.sv
// Concurrent checks on the multi-lane read sequencer ports
`timescale 1ns/100ps
`default_nettype none
module mfr_sequencer_checker (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_sck,
    input wire logic       i_cs_n,
    input wire logic       i_quad_enable,
    input wire logic [3:0] o_io,
    input wire logic [3:0] o_io_oe,
    input wire logic       o_busy,
    input wire logic       o_execute_in_place
);
    logic       sck_q;
    logic [3:0] fall_age;
    logic [3:0] cs_age;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Ages saturate so a long idle gap never wraps into a false match
    always_ff @(posedge i_clk) begin
        sck_q <= i_sck;
        if (i_reset || (sck_q && !i_sck)) fall_age <= (i_reset ? 4'hF : 4'h0);
        else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
    end
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_cs_n) cs_age <= 4'h0;
        else if (cs_age != 4'hF) cs_age <= cs_age + 4'h1;
    end
    a_idle_quiet: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
        else $error("lines driven while deselected");
    a_lane_shape: assert property (o_io_oe inside {4'h0, 4'h3, 4'hF})
        else $error("drive enables not a lane group");
    a_quad_gate: assert property (!i_quad_enable |-> o_io_oe != 4'hF)
        else $error("four lanes driven while disabled");
    a_change_on_fall: assert property (($changed(o_io) && o_io_oe != 4'h0
        && $past(o_io_oe) != 4'h0) |-> fall_age inside {[1:6]})
        else $error("data changed away from a falling edge");
    a_start_on_fall: assert property ($rose(|o_io_oe) |-> fall_age inside {[1:6]})
        else $error("data started away from a falling edge");
    a_oe_drop: assert property ($rose(i_cs_n) |-> ##[1:6] o_io_oe == 4'h0)
        else $error("lines still driven after deselect");
    a_busy_idle: assert property (i_cs_n [*6] |-> !o_busy)
        else $error("busy while deselected");
    a_busy_frame: assert property (!i_cs_n [*6] |-> o_busy)
        else $error("not busy inside a frame");
    a_cont_exit: assert property ($fell(o_execute_in_place) |-> cs_age inside {[1:6]})
        else $error("continuous mode left away from select rise");
    c_cont_on: cover property ($rose(o_execute_in_place));
    c_cont_off: cover property ($fell(o_execute_in_place));
    c_quad_data: cover property ($rose(o_io_oe == 4'hF));
endmodule
bind mfr_sequencer mfr_sequencer_checker mfr_sequencer_checker_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .i_quad_enable(i_quad_enable), .o_io(o_io), .o_io_oe(o_io_oe), .o_busy(o_busy),
    .o_execute_in_place(o_execute_in_place));
`default_nettype wire

// File: mfr_host_model.sv
// Host controller model driving serial clock, select and the IO lines
`timescale 1ns/100ps
`default_nettype none
module mfr_host_model (
    input  wire logic [3:0] i_io,
    output logic            o_sck,
    output logic            o_cs_n,
    output logic [3:0]      o_io
);
    int half = 400;
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'h5;
    end
    // Change on the fall, device samples on the rise; released lines flip
    // every cycle so a stale value never reads back as data
    task automatic cyc(input logic [3:0] v, input logic [3:0] m);
        o_sck = 1'b0;
        o_io  = (v & m) | (~o_io & ~m);
        #(half);
        o_sck = 1'b1;
        #(half);
    endtask
    task automatic start();
        o_cs_n = 1'b0;
        #(half);
    endtask
    task automatic shift(input int n, input int w, input logic [31:0] v);
        for (int i = n - 1; i >= 0; i--)
            cyc(4'(v >> (i * w)), (w == 1) ? 4'h1 : 4'h3);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(4'h0, 4'h0);
    endtask
    task automatic read(input int n, input int w, output logic [63:0] d);
        d = 64'h0;
        repeat (n) begin
            cyc(4'h0, 4'h0);
            d = (d << w) | 64'(i_io & ((w == 4) ? 4'hF : 4'h3));
        end
    endtask
    // Select rises with the clock held low; the short-frame test also calls it right after four address cycles
    task automatic stop();
        o_sck = 1'b0;
        #(half);
        o_cs_n = 1'b1;
        #(2 * half);
    endtask
endmodule
`default_nettype wire

// File: mfr_sequencer_tb_top.sv
// Self-checking bench for the multi-lane read sequencer
`timescale 1ns/100ps
`default_nettype none
module mfr_sequencer_tb_top;
    logic       i_clk, i_reset, sck, cs_n, fbs, qen, enh, we, busy, cont_flag, xe;
    logic [3:0] h_io, d_io, d_oe, io;
    logic [1:0] lat;
    logic [7:0] bank, wa, wd, lop, mem [256];
    logic [7:0] ops [6] = '{8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC};
    int         mismatches = 0, n_compared = 0;
    assign io = (d_oe & d_io) | (~d_oe & h_io);
    mfr_sequencer #(.ARRAY_AW(8)) mfr_sequencer_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_sck(sck), .i_cs_n(cs_n), .i_io(io),
        .o_io(d_io), .o_io_oe(d_oe), .i_four_byte_addr_select(fbs),
        .i_quad_enable(qen), .i_latency_code(lat), .i_enhanced_latency_table(enh),
        .i_bank_addr(bank), .i_mem_we(we), .i_mem_waddr(wa), .i_mem_wdata(wd),
        .o_busy(busy), .o_execute_in_place(cont_flag));
    mfr_host_model mfr_host_model_i (.i_io(io), .o_sck(sck), .o_cs_n(cs_n), .o_io(h_io));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [63:0] exp_data(input logic [7:0] a);
        exp_data = 64'h0;
        for (int k = 0; k < 4; k++) exp_data = (exp_data << 8) | 64'(mem[8'(a + k)]);
    endfunction
    function automatic int dummy_of(input logic [7:0] op);
        if (lat == 2'h3) return 0;
        if (op[7:4] == 4'h3) return 8;
        return (lat == 2'h2) ? 5 : 4;
    endfunction
    task automatic cfg(input logic [1:0] l, input logic f, input logic e, input logic q);
        @(posedge i_clk);
        #1;
        lat = l;
        fbs = f;
        enh = e;
        qen = q;
    endtask
    // One read frame; in continuous mode the opcode is left out
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] mode);
        int          w, ab;
        logic        bad, cont;
        logic [63:0] got;
        cont = xe;
        if (cont) op = lop;
        w    = (op[7:4] == 4'h6) ? 4 : 2;
        ab   = (op[0] == 1'b0 || fbs) ? 32 : 24;
        bad  = !(op inside {ops}) || (w == 4 && !qen);
        mfr_host_model_i.start();
        if (!cont) mfr_host_model_i.shift(8, 1, {24'h0, op});
        if (op[7:4] == 4'hB) begin
            lop = op;
            mfr_host_model_i.shift(ab / 2, 2, a);
            if (enh) mfr_host_model_i.shift(4, 2, {24'h0, mode});
        end else
            mfr_host_model_i.shift(ab, 1, a);
        mfr_host_model_i.idle(dummy_of(op));
        mfr_host_model_i.read(32 / w, w, got);
        if (bad) check(64'(d_oe), 64'h0);
        else check(got, exp_data(a[7:0]));
        check(64'(busy), 64'h1);
        mfr_host_model_i.stop();
        xe = !bad && op[7:4] == 4'hB && enh && mode[7:4] == 4'hA;
        check(64'(cont_flag), 64'(xe));
        check(64'(busy), 64'h0);
    endtask
    initial begin
        repeat (95000) @(posedge i_clk);
        mismatches++;
        results();
    end
    initial begin
        {i_reset, fbs, qen, enh, we, xe} = 6'h28;
        lat  = 2'h0;
        bank = 8'h00;
        {wa, wd, lop} = 24'h0;
        void'($urandom(32'h227C));
        repeat (12) @(posedge i_clk);
        #1 i_reset = 1'b0;
        for (int i = 0; i < 256; i++) begin
            @(posedge i_clk);
            #1;
            we = 1'b1;
            wa = 8'(i);
            wd = 8'($urandom);
            mem[i] = wd;
        end
        @(posedge i_clk);
        #1 we = 1'b0;
        foreach (ops[i]) for (int l = 0; l < 4; l++) begin
            cfg(2'(l), 1'($urandom), 1'b0, 1'b1);
            rd(ops[i], $urandom, 8'h00);
        end
        $display("test opcodes and latency codes done");
        rd(8'h6C, 32'hFFFF_FFFE, 8'h00);
        rd(8'h3B, 32'h0000_00FD, 8'h00);
        rd(8'h5A, 32'h0000_0010, 8'h00);
        cfg(2'h1, 1'b0, 1'b0, 1'b0);
        rd(8'h6B, 32'h0000_0020, 8'h00);
        $display("test wrap and refusals done");
        mfr_host_model_i.half = 700;
        cfg(2'h2, 1'b0, 1'b1, 1'b1);
        rd(8'hBB, 32'h0000_0040, 8'hA5);
        rd(8'h00, 32'h0000_00F0, 8'hA3);
        rd(8'h00, 32'h0000_0011, 8'h5A);
        rd(8'h3B, 32'h0000_0012, 8'h00);
        rd(8'hBC, 32'h0000_0013, 8'hAF);
        mfr_host_model_i.start();
        mfr_host_model_i.shift(4, 2, 32'h0000_00FF);
        mfr_host_model_i.stop();
        xe = 1'b0;
        check(64'(cont_flag), 64'h0);
        rd(8'h6C, 32'h0000_0014, 8'h00);
        mfr_host_model_i.half = 400;
        $display("test continuous mode done");
        for (int i = 0; i < 20; i++) begin
            if (!xe) cfg(2'($urandom), 1'($urandom), 1'($urandom), 1'b1);
            rd(ops[$urandom % 6], $urandom, ($urandom % 2) ? 8'hA6 : 8'($urandom));
        end
        $display("test random frames done");
        results();
    end
endmodule
`default_nettype wire
